// ---- bsc_switchover.sv ----
// supply switch-over control, oscillator configuration and pin gating
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.svh"

// Notes on behaviour
// - Bit 4 of the oscillator register selects reduced clock jitter when set, normal when clear.
// - Oscillator bits 3:2 give normal drive for 00, low for 01 and high for 10 or 11.
// - Oscillator bits 1:0 give 7.0 pF for 00, 6.0 pF for 01 and 12.5 pF for 10 or 11.
// - The supply changed flag is set on every move from main power to battery.
// - The flag can only be read while running from main power.
// - Going to battery raises an interrupt as a pulse or a held low level; returning raises a pulse.
// - On battery the main domain is off and the serial clock and data lines are ignored.
// - On battery the clock output and timestamp output go Hi-Z and the timestamp input is ignored.
// - On battery the switch detector stays active and the first interrupt keeps events but no clock.
// - Bit 4 of the switch register disables the whole switch-over when set.
// - Bit 3 of the switch register holds the refresh rate, low by default and best left so.
// - Switch register bits 2:1 choose the comparison with threshold, battery, higher or lower.
// - Bit 0 of the switch register picks a 1.5 V threshold when clear and 2.8 V when set.
// - Once set the flag stays set until the host clears it by command.
// - The second interrupt output is active only on main power.
module bsc_switchover
(
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output var  logic [7:0]             regRdData,
    input  wire logic                   vddAboveTh,
    input  wire logic                   vddAboveBat,
    input  wire logic                   serialClkIn,
    input  wire logic                   serialDataIn,
    input  wire logic                   timestampPinIn,
    input  wire logic                   timestampSwitchIn,
    input  wire logic                   clkSource,
    input  wire logic                   timestampOutData,
    input  wire logic                   timestampOutReq,
    input  wire logic                   otherIrqFirst,
    input  wire logic                   otherIrqSecond,
    output var  logic                   onBattery,
    output var  logic                   mainDomainEnable,
    output var  logic                   serialClkQual,
    output var  logic                   serialDataQual,
    output var  logic                   timestampInQual,
    output var  logic                   timestampSwitchQual,
    output var  logic                   clkOut,
    output var  logic                   clkOutEn,
    output var  logic                   timestampOut,
    output var  logic                   timestampOutEn,
    output var  logic                   interruptOutFirstN,
    output var  logic                   interruptOutSecondN,
    output var  logic                   reducedJitterSelect,
    output var  bsc_pkg::bsc_drive_type crystalDriveStrength,
    output var  bsc_pkg::bsc_load_type  loadCapacitanceSelect,
    output var  logic                   switchRefreshRate,
    output var  logic                   thresholdSelect,
    output var  logic [1:0]             switchoverModeSelect,
    output var  logic                   irqOut
);
    import bsc_pkg::*;

    function automatic bsc_drive_type decodeDrive(input logic [1:0] f);
        decodeDrive = (f == 2'h0) ? BSC_DRV_NORMAL : (f == 2'h1) ? BSC_DRV_LOW : BSC_DRV_HIGH;
    endfunction

    function automatic bsc_load_type decodeLoad(input logic [1:0] f);
        decodeLoad = (f == 2'h0) ? BSC_CL_7P0 : (f == 2'h1) ? BSC_CL_6P0 : BSC_CL_12P5;
    endfunction

    localparam int PULSE_CYCLES = `BSC_PULSE_CYCLES;

    logic [7:0]    oscCtrl_reg;
    logic [7:0]    swCtrl_reg;
    logic          flag_reg;
    logic [1:0]    irqStatus_reg;
    logic [1:0]    irqMask_reg;
    logic          levelMode_reg;
    bsc_state_type state_reg;
    bsc_state_type state_next;
    logic [1:0]    thSync_reg;
    logic [1:0]    batSync_reg;
    logic [1:0]    sclSync_reg;
    logic [1:0]    sdaSync_reg;
    logic [1:0]    tsSync_reg;
    logic [1:0]    swSync_reg;
    logic [17:0]   pulseCnt_reg;
    logic          supplyMain;
    logic          toBattery;
    logic          toMain;
    logic          wrOsc;
    logic          wrSw;
    logic          wrFlag;
    logic          rdStatus;
    logic          busLive;

    // two-flop synchronisers for pins and comparators
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            thSync_reg  <= 2'h3;
            batSync_reg <= 2'h3;
            sclSync_reg <= 2'h0;
            sdaSync_reg <= 2'h0;
            tsSync_reg  <= 2'h0;
            swSync_reg  <= 2'h0;
        end
        else
        begin
            thSync_reg  <= {thSync_reg[0], vddAboveTh};
            batSync_reg <= {batSync_reg[0], vddAboveBat};
            sclSync_reg <= {sclSync_reg[0], serialClkIn};
            sdaSync_reg <= {sdaSync_reg[0], serialDataIn};
            tsSync_reg  <= {tsSync_reg[0], timestampPinIn};
            swSync_reg  <= {swSync_reg[0], timestampSwitchIn};
        end
    end

    // supply verdict from the selected comparison
    always_comb
    begin
        unique case (swCtrl_reg[`BSC_SW_MODE_HI:`BSC_SW_MODE_LO])
            2'h0: supplyMain = thSync_reg[1];
            2'h1: supplyMain = batSync_reg[1];
            2'h2: supplyMain = thSync_reg[1] & batSync_reg[1];
            2'h3: supplyMain = thSync_reg[1] | batSync_reg[1];
        endcase
        if (swCtrl_reg[`BSC_SW_OFF_BIT])
            supplyMain = 1'b1;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            BSC_ST_MAIN:    if (!supplyMain) state_next = BSC_ST_BATTERY;
            BSC_ST_BATTERY: if (supplyMain)  state_next = BSC_ST_MAIN;
            default:        state_next = BSC_ST_MAIN;
        endcase
    end

    assign toBattery = (state_reg == BSC_ST_MAIN) && (state_next == BSC_ST_BATTERY);
    assign toMain    = (state_reg == BSC_ST_BATTERY) && (state_next == BSC_ST_MAIN);
    assign busLive   = (state_reg == BSC_ST_MAIN);
    assign wrOsc     = busLive && regWrite && (regAddr == `BSC_ADDR_OSC_CTRL);
    assign wrSw      = busLive && regWrite && (regAddr == `BSC_ADDR_SW_CTRL);
    assign wrFlag    = busLive && regWrite && (regAddr == `BSC_ADDR_FLAGS);
    assign rdStatus  = busLive && regRead && (regAddr == `BSC_ADDR_IRQ_STATUS);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= BSC_ST_MAIN;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            oscCtrl_reg <= `BSC_OSC_RESET;
            swCtrl_reg  <= `BSC_SW_RESET;
        end
        else
        begin
            if (wrOsc)
                oscCtrl_reg <= regWrData & `BSC_OSC_WMASK;
            if (wrSw)
                swCtrl_reg <= regWrData & `BSC_SW_WMASK;
        end
    end

    // sticky flag; the set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            flag_reg <= 1'b0;
        else if (toBattery)
            flag_reg <= 1'b1;
        else if (wrFlag && !regWrData[`BSC_FLAG_BIT])
            flag_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irqMask_reg   <= 2'h0;
            levelMode_reg <= 1'b0;
        end
        else
        begin
            if (busLive && regWrite && regAddr == `BSC_ADDR_IRQ_MASK)
                irqMask_reg <= regWrData[1:0];
            if (busLive && regWrite && regAddr == `BSC_ADDR_IRQ_CFG)
                levelMode_reg <= regWrData[`BSC_CFG_LEVEL_BIT];
        end
    end

    // status cleared by read, events win
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            irqStatus_reg <= 2'h0;
        else
            irqStatus_reg <= (rdStatus ? 2'h0 : irqStatus_reg) | {toMain, toBattery};
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            irqOut <= 1'b0;
        else
            irqOut <= |(irqStatus_reg & irqMask_reg);
    end

    // pulse timer on every supply change
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            pulseCnt_reg <= 18'h0;
        else if (toBattery || toMain)
            pulseCnt_reg <= 18'(PULSE_CYCLES);
        else if (pulseCnt_reg != 18'h0)
            pulseCnt_reg <= pulseCnt_reg - 18'h1;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            regRdData <= 8'h00;
        else if (!regRead || !busLive)
            regRdData <= 8'h00;
        else
        begin
            unique case (regAddr)
                `BSC_ADDR_OSC_CTRL:   regRdData <= oscCtrl_reg;
                `BSC_ADDR_SW_CTRL:    regRdData <= {3'h0, swCtrl_reg[4:0]};
                `BSC_ADDR_FLAGS:      regRdData <= {7'h0, flag_reg};
                `BSC_ADDR_IRQ_STATUS: regRdData <= {6'h0, irqStatus_reg};
                `BSC_ADDR_IRQ_MASK:   regRdData <= {6'h0, irqMask_reg};
                `BSC_ADDR_IRQ_CFG:    regRdData <= {7'h0, levelMode_reg};
                default:              regRdData <= 8'h00;
            endcase
        end
    end

    // pin gating and configuration outputs
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            onBattery             <= 1'b0;
            mainDomainEnable      <= 1'b0;
            serialClkQual         <= 1'b1;
            serialDataQual        <= 1'b1;
            timestampInQual       <= 1'b0;
            timestampSwitchQual   <= 1'b0;
            clkOut                <= 1'b0;
            clkOutEn              <= 1'b0;
            timestampOut          <= 1'b0;
            timestampOutEn        <= 1'b0;
            interruptOutFirstN    <= 1'b1;
            interruptOutSecondN   <= 1'b1;
            reducedJitterSelect   <= 1'b0;
            crystalDriveStrength  <= BSC_DRV_NORMAL;
            loadCapacitanceSelect <= BSC_CL_7P0;
            switchRefreshRate     <= 1'b0;
            thresholdSelect       <= 1'b0;
            switchoverModeSelect  <= 2'h0;
        end
        else
        begin
            onBattery             <= !busLive;
            mainDomainEnable      <= busLive;
            serialClkQual         <= busLive ? sclSync_reg[1] : 1'b1;
            serialDataQual        <= busLive ? sdaSync_reg[1] : 1'b1;
            timestampInQual       <= busLive & tsSync_reg[1];
            timestampSwitchQual   <= swSync_reg[1];
            clkOut                <= busLive & clkSource;
            clkOutEn              <= busLive;
            timestampOut          <= busLive & timestampOutData;
            timestampOutEn        <= busLive & timestampOutReq;
            interruptOutFirstN    <= !(otherIrqFirst
                                     || (pulseCnt_reg != 18'h0)
                                     || (levelMode_reg && flag_reg));
            interruptOutSecondN   <= !(busLive && (otherIrqSecond
                                     || (pulseCnt_reg != 18'h0)));
            reducedJitterSelect   <= oscCtrl_reg[`BSC_OSC_REDUCED_JITTER_SELECT_BIT];
            crystalDriveStrength  <= decodeDrive(oscCtrl_reg[3:2]);
            loadCapacitanceSelect <= decodeLoad(oscCtrl_reg[1:0]);
            switchRefreshRate     <= swCtrl_reg[`BSC_SW_RR_BIT];
            thresholdSelect       <= swCtrl_reg[`BSC_SW_TH_BIT];
            switchoverModeSelect  <= swCtrl_reg[2:1];
        end
    end

    a_flag_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
        toBattery |=> flag_reg)
        else $error("flag not set on move to battery");

    a_flag_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
        flag_reg && !wrFlag |=> flag_reg)
        else $error("flag dropped without clear");

    a_bus_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
        !busLive && regWrite |=> $stable(oscCtrl_reg) && $stable(swCtrl_reg))
        else $error("register written on battery");

    a_clk_hiz: assert property (@(posedge sys_clk) disable iff (!nrst)
        !busLive |=> !clkOutEn && !timestampOutEn && !timestampInQual)
        else $error("outputs driven on battery");

    a_second_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
        !busLive |=> interruptOutSecondN)
        else $error("second interrupt active on battery");

    sequence s_change;
        toBattery || toMain;
    endsequence
    a_pulse_raised: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_change |=> ##1 !interruptOutFirstN [*2])
        else $error("no interrupt pulse on supply change");

    a_level_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
        levelMode_reg && flag_reg |=> !interruptOutFirstN)
        else $error("first interrupt not following flag");

    a_disable_main: assert property (@(posedge sys_clk) disable iff (!nrst)
        swCtrl_reg[`BSC_SW_OFF_BIT] |-> !toBattery)
        else $error("switch event while disabled");

    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        regRead && busLive && regAddr == `BSC_ADDR_SW_CTRL |=> regRdData[7:5] == 3'h0)
        else $error("reserved bits read nonzero");

    a_drive_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
        oscCtrl_reg[3] && $stable(oscCtrl_reg) |=> crystalDriveStrength == BSC_DRV_HIGH)
        else $error("drive decode wrong");

endmodule
`default_nettype wire

// ---- bsc_defines.svh ----
// register offsets, field positions and reset values of the supply switch-over block
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

`define BSC_ADDR_OSC_CTRL     8'h25
`define BSC_ADDR_SW_CTRL      8'h26
`define BSC_ADDR_FLAGS        8'h2B
`define BSC_ADDR_IRQ_STATUS   8'h40
`define BSC_ADDR_IRQ_MASK     8'h41
`define BSC_ADDR_IRQ_CFG      8'h42

`define BSC_OSC_REDUCED_JITTER_SELECT_BIT      4
`define BSC_OSC_DRV_HI        3
`define BSC_OSC_DRV_LO        2
`define BSC_OSC_CL_HI         1
`define BSC_OSC_CL_LO         0
`define BSC_OSC_RESET         8'h00
`define BSC_OSC_WMASK         8'hFF

`define BSC_SW_OFF_BIT        4
`define BSC_SW_RR_BIT         3
`define BSC_SW_MODE_HI        2
`define BSC_SW_MODE_LO        1
`define BSC_SW_TH_BIT         0
`define BSC_SW_RESET          8'h00
`define BSC_SW_WMASK          8'h1F

`define BSC_FLAG_BIT          0
`define BSC_IRQ_TOBAT_BIT     0
`define BSC_IRQ_TOMAIN_BIT    1
`define BSC_CFG_LEVEL_BIT     0

`define BSC_PULSE_NS          7812500
`define BSC_CLK_NS            50
`define BSC_PULSE_CYCLES      ((`BSC_PULSE_NS) / (`BSC_CLK_NS))

`endif

// ---- bsc_pkg.sv ----
// types of the supply switch-over block
package bsc_pkg;

    typedef enum logic [1:0]
    {
        BSC_DRV_NORMAL = 2'h0,
        BSC_DRV_LOW    = 2'h1,
        BSC_DRV_HIGH   = 2'h2
    } bsc_drive_type;

    typedef enum logic [1:0]
    {
        BSC_CL_7P0  = 2'h0,
        BSC_CL_6P0  = 2'h1,
        BSC_CL_12P5 = 2'h2
    } bsc_load_type;

    typedef enum logic [1:0]
    {
        BSC_ST_MAIN    = 2'b01,
        BSC_ST_BATTERY = 2'b10
    } bsc_state_type;

endpackage

// ---- bsc_supply_model.sv ----
// behavioural model of the analog supply comparators
`timescale 1ns/1ps
`default_nettype none
module bsc_supply_model
#(
    parameter int TH_LOW_MV  = 1500,
    parameter int TH_HIGH_MV = 2800
)
(
    input  wire logic sys_clk,
    input  var  int   vddMv,
    input  var  int   batMv,
    input  wire logic thresholdSelect,
    output var  logic vddAboveTh,
    output var  logic vddAboveBat
);
    // threshold follows the select bit of the block
    always @(posedge sys_clk)
    begin
        vddAboveTh  <= vddMv > (thresholdSelect ? TH_HIGH_MV : TH_LOW_MV);
        vddAboveBat <= vddMv > batMv;
    end
endmodule
`default_nettype wire

// ---- tb_battery_switchover_control.sv ----
// self-checking bench of the supply switch-over block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.svh"
module tb_battery_switchover_control;
    import bsc_pkg::*;
    logic          sys_clk = 1'b0;
    logic          nrst = 1'b0;
    logic [7:0]    regAddr = 8'h00;
    logic [7:0]    regWrData = 8'h00;
    logic          regWrite = 1'b0;
    logic          regRead = 1'b0;
    logic [7:0]    regRdData;
    logic          vddAboveTh, vddAboveBat;
    logic          serialClkIn = 1'b0;
    logic          serialDataIn = 1'b0;
    logic          timestampPinIn = 1'b1;
    logic          timestampSwitchIn = 1'b1;
    logic          clkSource = 1'b1;
    logic          timestampOutData = 1'b1;
    logic          timestampOutReq = 1'b1;
    logic          otherIrqFirst = 1'b0;
    logic          otherIrqSecond = 1'b0;
    logic          onBattery, mainDomainEnable, serialClkQual, serialDataQual;
    logic          timestampInQual, timestampSwitchQual, clkOut, clkOutEn;
    logic          timestampOut, timestampOutEn, interruptOutFirstN, interruptOutSecondN;
    logic          reducedJitterSelect, switchRefreshRate, thresholdSelect, irqOut;
    logic [1:0]    switchoverModeSelect;
    bsc_drive_type crystalDriveStrength;
    bsc_load_type  loadCapacitanceSelect;
    int            vddMv = 3500;
    int            batMv = 3000;
    int            failures = 0;
    int            n_compared = 0;
    int            cycles = 0;

    bsc_switchover i_dut (.sys_clk, .nrst, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .vddAboveTh, .vddAboveBat, .serialClkIn, .serialDataIn, .timestampPinIn,
        .timestampSwitchIn, .clkSource, .timestampOutData, .timestampOutReq, .otherIrqFirst,
        .otherIrqSecond, .onBattery, .mainDomainEnable, .serialClkQual, .serialDataQual,
        .timestampInQual, .timestampSwitchQual, .clkOut, .clkOutEn, .timestampOut,
        .timestampOutEn, .interruptOutFirstN, .interruptOutSecondN, .reducedJitterSelect,
        .crystalDriveStrength, .loadCapacitanceSelect, .switchRefreshRate, .thresholdSelect,
        .switchoverModeSelect, .irqOut);

    bsc_supply_model i_supply (.sys_clk, .vddMv, .batMv, .thresholdSelect, .vddAboveTh,
        .vddAboveBat);

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, far above the expected run length
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict;
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // move the main supply and let syncs and gating settle
    task automatic supply(input int mv);
        @(posedge sys_clk);
        vddMv <= mv;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset;
        logic [7:0] d;
        rd(`BSC_ADDR_OSC_CTRL, d);
        chk8(d, 8'h00);
        rd(`BSC_ADDR_SW_CTRL, d);
        chk8(d, 8'h00);
        chk8({3'h0, switchRefreshRate, switchoverModeSelect, thresholdSelect, onBattery}, 8'h00);
        chk8({5'h0, interruptOutFirstN, interruptOutSecondN, irqOut}, 8'h06);
        $display("test reset done");
    endtask

    task automatic t_osc;
        logic [7:0] d;
        logic [1:0] e;
        for (int i = 0; i < 4; i++)
        begin
            e = (i == 0) ? 2'h0 : (i == 1) ? 2'h1 : 2'h2;
            wr(`BSC_ADDR_OSC_CTRL, {3'h0, i[0], i[1:0], i[1:0]});
            rd(`BSC_ADDR_OSC_CTRL, d);
            chk8(d, {3'h0, i[0], i[1:0], i[1:0]});
            chk8({7'h0, reducedJitterSelect}, {7'h0, i[0]});
            chk8({6'h0, crystalDriveStrength}, {6'h0, e});
            chk8({6'h0, loadCapacitanceSelect}, {6'h0, e});
        end
        $display("test oscillator done");
    endtask

    task automatic t_swreg;
        logic [7:0] d;
        wr(`BSC_ADDR_SW_CTRL, 8'hFF);
        rd(`BSC_ADDR_SW_CTRL, d);
        chk8(d, 8'h1F);
        chk8({4'h0, switchRefreshRate, switchoverModeSelect, thresholdSelect}, 8'h0F);
        $display("test switch register done");
    endtask

    task automatic t_battery;
        logic [7:0] d;
        wr(`BSC_ADDR_SW_CTRL, 8'h00);
        wr(`BSC_ADDR_IRQ_MASK, 8'h03);
        rd(`BSC_ADDR_IRQ_STATUS, d);
        wr(`BSC_ADDR_FLAGS, 8'h00);
        supply(1000);
        chk8({onBattery, mainDomainEnable, serialClkQual, serialDataQual, timestampInQual,
              clkOutEn, timestampOutEn, timestampSwitchQual}, 8'hB1);
        chk8({5'h0, interruptOutFirstN, interruptOutSecondN, irqOut}, 8'h03);
        wr(`BSC_ADDR_OSC_CTRL, 8'h00);
        rd(`BSC_ADDR_FLAGS, d);
        chk8(d, 8'h00);
        supply(3500);
        chk8({4'h0, onBattery, mainDomainEnable, serialClkQual, timestampInQual}, 8'h05);
        chk8({clkOut, clkOutEn, timestampOut, timestampOutEn, interruptOutFirstN,
              interruptOutSecondN, serialDataQual, 1'b0}, 8'hF0);
        rd(`BSC_ADDR_OSC_CTRL, d);
        chk8(d, 8'h1F);
        rd(`BSC_ADDR_FLAGS, d);
        chk8(d, 8'h01);
        rd(`BSC_ADDR_FLAGS, d);
        chk8(d, 8'h01);
        rd(`BSC_ADDR_IRQ_STATUS, d);
        chk8(d, 8'h03);
        rd(`BSC_ADDR_IRQ_STATUS, d);
        chk8(d, 8'h00);
        chk8({7'h0, irqOut}, 8'h00);
        wr(`BSC_ADDR_FLAGS, 8'h00);
        rd(`BSC_ADDR_FLAGS, d);
        chk8(d, 8'h00);
        $display("test battery done");
    endtask

    task automatic t_disable;
        logic [7:0] d;
        wr(`BSC_ADDR_IRQ_MASK, 8'h00);
        wr(`BSC_ADDR_SW_CTRL, 8'h10);
        supply(1000);
        chk8({7'h0, onBattery}, 8'h00);
        wr(`BSC_ADDR_SW_CTRL, 8'h00);
        supply(1000);
        chk8({6'h0, onBattery, irqOut}, 8'h02);
        supply(3500);
        rd(`BSC_ADDR_IRQ_STATUS, d);
        chk8(d, 8'h03);
        $display("test disable done");
    endtask

    task automatic t_modes;
        logic [3:0] onBat;
        onBat = 4'b0110;
        for (int m = 0; m < 4; m++)
        begin
            wr(`BSC_ADDR_SW_CTRL, {5'h0, m[1:0], 1'b0});
            supply(2000);
            chk8({7'h0, onBattery}, {7'h0, onBat[m]});
            supply(3500);
        end
        wr(`BSC_ADDR_SW_CTRL, 8'h01);
        supply(2000);
        chk8({7'h0, onBattery}, 8'h01);
        supply(3500);
        $display("test modes done");
    endtask

    task automatic t_level;
        logic [7:0] d;
        wr(`BSC_ADDR_IRQ_CFG, 8'h01);
        wr(`BSC_ADDR_FLAGS, 8'h00);
        supply(1000);
        chk8({7'h0, interruptOutFirstN}, 8'h00);
        supply(3500);
        rd(`BSC_ADDR_IRQ_CFG, d);
        chk8(d, 8'h01);
        rd(`BSC_ADDR_IRQ_MASK, d);
        chk8(d, 8'h00);
        rd(`BSC_ADDR_FLAGS, d);
        chk8(d, 8'h01);
        wr(`BSC_ADDR_IRQ_CFG, 8'h00);
        $display("test level done");
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_osc();
        t_swreg();
        t_battery();
        t_disable();
        t_modes();
        t_level();
        print_verdict();
    end
endmodule
`default_nettype wire
